// file: src/ccp_core_clock_power_control.sv
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ccp_consts.svh"

module ccp_core_clock_power_control #(
	parameter int LOCK_TARGET = `CCP_PLL_MULT,
	parameter int LOCK_TOL    = `CCP_LOCK_TOL,
	parameter int AW          = 8
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          ce,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          wvalid,
	output logic               wready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	output logic               bvalid,
	input  wire logic          bready,
	output logic [1:0]         bresp,
	input  wire logic          arvalid,
	output logic               arready,
	input  wire logic [AW-1:0] araddr,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	input  wire logic          oscIn,
	input  wire logic          externalClockPin,
	input  wire logic          externalIrqZero,
	input  wire logic          externalIrqOne,
	input  wire logic          timer2Wake,
	input  wire logic          timer3Wake,
	input  wire logic          irqActive,
	output logic               coreClockOutPin,
	output logic               coreClkEn,
	output logic               oscToTimer,
	output logic               pllLocked,
	output logic               poweredDown
);
	logic [1:0]         rstPipe;
	logic               rstN;
	ccp_pkg::ccp_pins_s pinRaw;
	ccp_pkg::ccp_pins_s pinS1;
	ccp_pkg::ccp_pins_s pinS2;
	ccp_pkg::ccp_pins_s pinS3;
	ccp_pkg::ccp_pins_s pinF;
	logic               oscLast;
	logic               extLast;
	logic [15:0]        periodCnt;
	logic [1:0]         goodCnt;
	logic [7:0]         awAddrQ;
	logic [7:0]         wDataQ;
	logic               wLaneQ;
	logic               doWrite;
	logic               wrOk;
	logic               mapped;
	logic [7:0]         clockSourceConfig;
	logic [7:0]         powerClockConfig;
	logic [7:0]         clkStage;
	logic [7:0]         pwrStage;
	ccp_pkg::ccp_key_e  clkKs;
	ccp_pkg::ccp_key_e  pwrKs;
	logic               boostActive;
	logic [1:0]         mdSel;
	logic [2:0]         pcSel;
	logic [2:0]         effDiv;
	logic               baseTick;
	logic [6:0]         divCnt;
	logic [6:0]         divMask;
	logic               coreTick;
	logic               wakeEvent;
	logic               pwrCommit;
	ccp_pkg::ccp_status_s status;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe <= 2'h0;
		end else if (ce) begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstN = rstPipe[1];

	assign pinRaw = '{externalIrqOne: externalIrqOne, externalIrqZero: externalIrqZero,
		externalClockPin: externalClockPin, osc: oscIn};

	// three-flop sync; a change counts only once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					pinS1[gi] <= 1'b0;
					pinS2[gi] <= 1'b0;
					pinS3[gi] <= 1'b0;
					pinF[gi]  <= 1'b0;
				end else if (ce) begin
					pinS1[gi] <= pinRaw[gi];
					pinS2[gi] <= pinS1[gi];
					pinS3[gi] <= pinS2[gi];
					if (pinS2[gi] == pinS3[gi]) begin
						pinF[gi] <= pinS3[gi];
					end
				end
			end
		end
	endgenerate

	// lock detect: clk cycles per oscillator period must lie within LOCK_TOL of the multiplier
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			oscLast   <= 1'b0;
			periodCnt <= 16'h0000;
			goodCnt   <= 2'h0;
			pllLocked <= 1'b0;
		end else if (ce) begin
			oscLast <= pinF.osc;
			if (pinF.osc && !oscLast) begin
				periodCnt <= 16'h0001;
				if (int'(periodCnt) >= LOCK_TARGET - LOCK_TOL &&
				    int'(periodCnt) <= LOCK_TARGET + LOCK_TOL) begin
					if (goodCnt != 2'h2) begin
						goodCnt <= goodCnt + 2'h1;
					end
				end else begin
					goodCnt <= 2'h0;
				end
				pllLocked <= (goodCnt == 2'h2) ||
					(goodCnt == 2'h1 && int'(periodCnt) >= LOCK_TARGET - LOCK_TOL &&
					 int'(periodCnt) <= LOCK_TARGET + LOCK_TOL);
			end else if (periodCnt != 16'hffff) begin
				periodCnt <= periodCnt + 16'h0001;
			end
		end
	end

	// bus slave: one write and one read under way at a time
	assign doWrite = !awready && !wready && !bvalid;
	assign wrOk    = doWrite && wLaneQ;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= `CCP_RESP_OKAY;
			awAddrQ <= 8'h00;
			wDataQ  <= 8'h00;
			wLaneQ  <= 1'b0;
		end else if (ce) begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awAddrQ <= awaddr[7:0];
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wDataQ <= wdata[7:0];
				wLaneQ <= wstrb[0];
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp  <= mapped ? `CCP_RESP_OKAY : `CCP_RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		unique case (awAddrQ)
			`CCP_OFS_CLK_KEY1, `CCP_OFS_CLK_CFG, `CCP_OFS_CLK_KEY2,
			`CCP_OFS_PWR_KEY, `CCP_OFS_PWR_CFG, `CCP_OFS_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// clock source key sequence
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			clkKs             <= ccp_pkg::KS_IDLE;
			clkStage          <= 8'h00;
			clockSourceConfig <= `CCP_RST_CLK_CFG;
		end else if (ce && wrOk) begin
			unique case (awAddrQ)
				`CCP_OFS_CLK_KEY1: begin
					clkKs <= (wDataQ == `CCP_KEY_CLK_A) ? ccp_pkg::KS_KEYED : ccp_pkg::KS_IDLE;
				end
				`CCP_OFS_CLK_CFG: begin
					if (clkKs == ccp_pkg::KS_KEYED) begin
						clkStage <= wDataQ & `CCP_CLK_CFG_MASK;
						clkKs    <= ccp_pkg::KS_VALUE;
					end else begin
						clkKs <= ccp_pkg::KS_IDLE;
					end
				end
				`CCP_OFS_CLK_KEY2: begin
					if (clkKs == ccp_pkg::KS_VALUE && wDataQ == `CCP_KEY_CLK_B) begin
						clockSourceConfig <= clkStage;
					end
					clkKs <= ccp_pkg::KS_IDLE;
				end
				default: begin
				end
			endcase
		end
	end

	// power key shares one location for both keys
	assign pwrCommit = wrOk && awAddrQ == `CCP_OFS_PWR_KEY &&
		pwrKs == ccp_pkg::KS_VALUE && wDataQ == `CCP_KEY_PWR_B;
	assign pcSel     = powerClockConfig[`CCP_PC_MSB:`CCP_PC_LSB];
	assign wakeEvent = pinF.externalIrqZero || pinF.externalIrqOne || timer2Wake || timer3Wake;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pwrKs            <= ccp_pkg::KS_IDLE;
			pwrStage         <= 8'h00;
			powerClockConfig <= `CCP_RST_PWR_CFG;
		end else if (ce) begin
			if (pwrCommit) begin
				powerClockConfig <= pwrStage;
			end else if (pcSel == `CCP_PC_PDOWN && wakeEvent) begin
				powerClockConfig[`CCP_PC_MSB:`CCP_PC_LSB] <= `CCP_PC_NORMAL;
			end
			if (wrOk && awAddrQ == `CCP_OFS_PWR_KEY) begin
				if (pwrCommit) begin
					pwrKs <= ccp_pkg::KS_IDLE;
				end else begin
					pwrKs <= (wDataQ == `CCP_KEY_PWR_A) ? ccp_pkg::KS_KEYED : ccp_pkg::KS_IDLE;
				end
			end else if (wrOk && awAddrQ == `CCP_OFS_PWR_CFG) begin
				if (pwrKs == ccp_pkg::KS_KEYED) begin
					pwrStage <= wDataQ & `CCP_PWR_CFG_MASK;
					pwrKs    <= ccp_pkg::KS_VALUE;
				end else begin
					pwrKs <= ccp_pkg::KS_IDLE;
				end
			end
		end
	end

	// boost starts once the boost bit is seen set during the service routine and holds for the rest of it
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			boostActive <= 1'b0;
		end else if (ce) begin
			boostActive <= irqActive && (boostActive || powerClockConfig[`CCP_FAST_IRQ_CLOCK_BOOST_BIT]);
		end
	end

	assign mdSel  = clockSourceConfig[`CCP_MD_MSB:`CCP_MD_LSB];
	assign effDiv = boostActive ? 3'h0 : powerClockConfig[`CCP_CD_MSB:`CCP_CD_LSB];
	// reserved mode codes fall back to the PLL so the core never loses its clock
	assign baseTick = (mdSel == `CCP_MD_EXT) ? (pinF.externalClockPin && !extLast) : 1'b1;
	assign divMask  = 7'((8'h01 << effDiv) - 8'h01);
	assign coreTick = baseTick && ((divCnt & divMask) == 7'h00);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			extLast         <= 1'b0;
			divCnt          <= 7'h00;
			coreClkEn       <= 1'b0;
			coreClockOutPin <= 1'b0;
		end else if (ce) begin
			extLast <= pinF.externalClockPin;
			if (baseTick) begin
				divCnt <= divCnt + 7'h01;
			end
			// power-down stops the core tick and parks the output low
			coreClkEn <= coreTick && (pcSel != `CCP_PC_PDOWN);
			if (pcSel == `CCP_PC_PDOWN) begin
				coreClockOutPin <= 1'b0;
			end else if (coreTick) begin
				coreClockOutPin <= !coreClockOutPin;
			end
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			oscToTimer  <= 1'b0;
			poweredDown <= 1'b0;
		end else if (ce) begin
			oscToTimer  <= clockSourceConfig[`CCP_TMR_OSC_BIT] && pinF.osc;
			poweredDown <= (pcSel == `CCP_PC_PDOWN);
		end
	end

	assign status = '{poweredDown: poweredDown, boostActive: boostActive,
		extClkSel: (mdSel == `CCP_MD_EXT), pllLocked: pllLocked};

	// read side; key locations read as zero
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `CCP_RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rresp   <= `CCP_RESP_OKAY;
				unique case (araddr[7:0])
					`CCP_OFS_CLK_CFG: rdata <= {24'h000000, clockSourceConfig};
					`CCP_OFS_PWR_CFG: rdata <= {24'h000000, powerClockConfig};
					`CCP_OFS_STATUS:  rdata <= {28'h0000000, status};
					`CCP_OFS_CLK_KEY1, `CCP_OFS_CLK_KEY2, `CCP_OFS_PWR_KEY: rdata <= 32'h00000000;
					default: begin
						rdata <= 32'h00000000;
						rresp <= `CCP_RESP_SLVERR;
					end
				endcase
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule : ccp_core_clock_power_control

// file: src/ccp_consts.svh
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
`define CCP_OFS_CLK_KEY1 8'h00
`define CCP_OFS_CLK_CFG  8'h04
`define CCP_OFS_CLK_KEY2 8'h08
`define CCP_OFS_PWR_KEY  8'h0c
`define CCP_OFS_PWR_CFG  8'h10
`define CCP_OFS_STATUS   8'h14
`define CCP_KEY_CLK_A    8'haa
`define CCP_KEY_CLK_B    8'h55
`define CCP_KEY_PWR_A    8'h01
`define CCP_KEY_PWR_B    8'hf4
`define CCP_RST_CLK_CFG  8'h01
`define CCP_RST_PWR_CFG  8'h03
`define CCP_CLK_CFG_MASK 8'h07
`define CCP_PWR_CFG_MASK 8'h7f
`define CCP_CD_LSB       0
`define CCP_CD_MSB       2
`define CCP_FAST_IRQ_CLOCK_BOOST_BIT     3
`define CCP_PC_LSB       4
`define CCP_PC_MSB       6
`define CCP_MD_LSB       0
`define CCP_MD_MSB       1
`define CCP_TMR_OSC_BIT  2
`define CCP_MD_PLL       2'h1
`define CCP_MD_EXT       2'h3
`define CCP_PC_NORMAL    3'h0
`define CCP_PC_PDOWN     3'h3
`define CCP_PLL_MULT     1376
`define CCP_OSC_KHZ      32.768
`define CCP_LOCK_TOL     16
`define CCP_RESP_OKAY    2'h0
`define CCP_RESP_SLVERR  2'h2
`endif

// file: src/ccp_pkg.sv
package ccp_pkg;
	typedef enum logic [2:0] {
		KS_IDLE  = 3'h1,
		KS_KEYED = 3'h2,
		KS_VALUE = 3'h4
	} ccp_key_e;

	typedef struct packed {
		logic poweredDown;
		logic boostActive;
		logic extClkSel;
		logic pllLocked;
	} ccp_status_s;

	typedef struct packed {
		logic externalIrqOne;
		logic externalIrqZero;
		logic externalClockPin;
		logic osc;
	} ccp_pins_s;
endpackage : ccp_pkg

// file: dv/ccp_cpc_properties.sv
`timescale 1ns/1ps
module ccp_cpc_properties #(
	parameter int LOCK_TARGET = 1376,
	parameter int LOCK_TOL    = 16,
	parameter int AW          = 8
) (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        ce,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic        timer2Wake,
	input wire logic        timer3Wake,
	input wire logic        coreClockOutPin,
	input wire logic        coreClkEn,
	input wire logic        poweredDown
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_write_answer_time: assert property (ce && awvalid && awready && wvalid && wready ##1 ce |-> !bvalid ##1 bvalid)
		else $error("write answer not two cycles after take");
	a_write_answer_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	a_read_answer_time: assert property (ce && arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_read_data_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed while waiting");
	a_write_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while answer pending");
	a_read_blocked: assert property (rvalid |-> !arready)
		else $error("read accepted while answer pending");
	a_pdown_quiet: assert property (poweredDown |-> !coreClkEn && !coreClockOutPin)
		else $error("core clock runs in power-down");
	// awready high means no keyed commit can land on the next edge
	// mode clears on the next edge, the registered flag follows one edge later
	a_timer_wake: assert property (ce && poweredDown && awready && (timer2Wake || timer3Wake) |-> ##2 !poweredDown)
		else $error("timer wake ignored");
endmodule : ccp_cpc_properties

bind ccp_core_clock_power_control ccp_cpc_properties #(
	.LOCK_TARGET(LOCK_TARGET),
	.LOCK_TOL(LOCK_TOL),
	.AW(AW)
) chk_u (.clk, .arst_n, .ce, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
	.arready, .rvalid, .rready, .rdata, .timer2Wake, .timer3Wake, .coreClockOutPin, .coreClkEn, .poweredDown);

// file: dv/test_ccp_core_clock_power_control.sv
`timescale 1ns/1ps
module test_ccp_core_clock_power_control;
	logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic        arready, rvalid, oscIn, extClk, irqActive, coreClockOutPin, coreClkEn;
	logic        oscToTimer, pllLocked, poweredDown;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wake;
	int          mismatches, checks, p;

	// short lock period keeps the run brief
	ccp_core_clock_power_control #(.LOCK_TARGET(80), .LOCK_TOL(2)) dut_u (.clk, .arst_n, .ce(1'b1), .awvalid,
		.awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .oscIn, .externalClockPin(extClk), .externalIrqZero(wake[0]),
		.externalIrqOne(wake[1]), .timer2Wake(wake[2]), .timer3Wake(wake[3]), .irqActive, .coreClockOutPin,
		.coreClkEn, .oscToTimer, .pllLocked, .poweredDown);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always begin
		repeat (40) @(posedge clk);
		oscIn <= ~oscIn;
	end
	always begin
		repeat (5) @(posedge clk);
		extClk <= ~extClk;
	end

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : ck

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		awaddr  <= a;
		wdata   <= {24'h0, d};
		do @(negedge clk); while (!(awready && wready));
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(negedge clk); while (!bvalid);
		ck(32'(bresp), 32'(er));
		@(posedge clk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		@(posedge clk);
		arvalid <= 1'b1;
		rready  <= 1'b1;
		araddr  <= a;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		ck(rdata, e);
		ck(32'(rresp), 32'(er));
		@(posedge clk);
		rready <= 1'b0;
	endtask : rd

	task automatic pw(input logic [7:0] v);
		wr(8'h0c, 8'h01);
		wr(8'h10, v);
		wr(8'h0c, 8'hf4);
		// outputs launched by the commit settle before anyone looks at them
		@(negedge clk);
	endtask : pw

	// counts core ticks and clock pin edges, which must agree
	task automatic cnt(input int n, input int e);
		logic last;
		int   t;
		p = 0;
		t = 0;
		last = coreClockOutPin;
		repeat (n) begin
			@(negedge clk);
			p += int'(coreClkEn !== 1'b0);
			t += int'(coreClockOutPin !== last);
			last = coreClockOutPin;
		end
		ck(32'(p), 32'(e));
		ck(32'(t), 32'(e));
	endtask : cnt

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		give_verdict();
	end

	initial begin
		{arst_n, awvalid, wvalid, bready, arvalid, rready, oscIn, extClk, irqActive, wake} = '0;
		{awaddr, araddr, wdata} = '0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h04, 32'h01);
		rd(8'h10, 32'h03);
		rd(8'h18, 32'h0, 2'h2);
		wr(8'h18, 8'h00, 2'h2);
		cnt(256, 32);
		$display("reset test done");
		for (int d = 0; d < 8; d++) begin
			pw(8'(d));
			rd(8'h10, 32'(d));
			repeat ((1 << d) + 8) @(posedge clk);
			cnt(256, 256 >> d);
		end
		$display("divider test done");
		wr(8'h10, 8'h05);
		wr(8'h0c, 8'h02);
		wr(8'h10, 8'h05);
		wr(8'h0c, 8'hf4);
		pw(8'h01);
		wr(8'h0c, 8'h01);
		wr(8'h10, 8'h05);
		wr(8'h0c, 8'h55);
		rd(8'h10, 32'h01);
		ck(32'(oscToTimer), 32'h0);
		wr(8'h00, 8'haa);
		wr(8'h04, 8'hfc);
		wr(8'h08, 8'h55);
		rd(8'h04, 32'h04);
		pw(8'h00);
		@(oscIn);
		repeat (8) @(negedge clk);
		ck(32'(oscToTimer), 32'(oscIn));
		ck(32'(pllLocked), 32'h1);
		rd(8'h14, 32'h01);
		// the external pin clock has period 10, so 200 cycles hold 20 ticks
		wr(8'h00, 8'haa);
		wr(8'h04, 8'h03);
		wr(8'h08, 8'h55);
		repeat (12) @(posedge clk);
		cnt(200, 20);
		$display("key and mode test done");
		for (int w = 0; w < 4; w++) begin
			pw(8'h30);
			ck(32'(poweredDown), 32'h1);
			cnt(40, 0);
			@(posedge clk) wake[w] <= 1'b1;
			// pin wakes pass the three-flop sync before the mode clears
			repeat (8) @(negedge clk);
			ck(32'(poweredDown), 32'h0);
			@(posedge clk) wake <= '0;
		end
		$display("power-down test done");
		pw(8'h0b);
		@(posedge clk) irqActive <= 1'b1;
		repeat (20) @(posedge clk);
		cnt(200, 20);
		@(posedge clk) irqActive <= 1'b0;
		repeat (100) @(posedge clk);
		cnt(240, 3);
		$display("boost test done");
		give_verdict();
	end
endmodule : test_ccp_core_clock_power_control
